//--- design/cic_top.sv
// Interrupt enable and flag logic with APB register access
`timescale 1ns/1ns
`default_nettype none
`include "cic_defines.svh"

// Overview of operation
// - Flags set on their source event regardless of any enable bit.
// - Bit 7 is global enable; zero blocks core_irq_req, while the irq output ignores it.
// - Bit 6 is the peripheral group enable; no source belongs to the group, so it blocks nothing.
// - Bit 5 enables the timer overflow interrupt.
// - Bit 4 enables the external pin interrupt.
// - Bit 3 enables the port pin-change interrupt.
// - Bit 2 set on timer overflow, held until firmware writes zero.
// - Bit 1 set on external pin event, held until firmware clears it.
// - Bit 0 set when any upper port pin changes, held until cleared.
// - Control register answers at both bank addresses with identical contents.
// - Control register fully readable and writable, holds all enables and flags.
// - Lowest port pin selectable as external interrupt input feeding its flag.
module cic_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_zero_overflow,
  input wire logic [7:0] port_pins,
  input wire logic ext_irq_alt_in,
  output logic core_irq_req,
  output logic irq
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic access;
  logic wr;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic hit_cfg;
  logic wr_ctrl;
  logic unmapped;

  assign access = psel && penable;
  assign wr = access && pwrite && pstrb[0];
  // both bank aliases decode to one register
  assign hit_ctrl = (paddr == {2'h0, `CIC_IDX_CTRL_BANK0, 2'h0})
                 || (paddr == {2'h0, `CIC_IDX_CTRL_BANK1, 2'h0});
  assign hit_stat = (paddr == {2'h0, `CIC_IDX_IRQ_STATUS, 2'h0});
  assign hit_mask = (paddr == {2'h0, `CIC_IDX_IRQ_MASK, 2'h0});
  assign hit_cfg = (paddr == {2'h0, `CIC_IDX_PORT_CFG, 2'h0});
  assign wr_ctrl = wr && hit_ctrl;
  assign unmapped = !(hit_ctrl || hit_stat || hit_mask || hit_cfg);
  assign pready = 1'b1;
  assign pslverr = access && unmapped;

  // ****************************************
  // Event detection
  // ****************************************
  cic_pkg::cic_ctrl_t ctrl;
  cic_pkg::cic_events_t ev;
  logic [1:0] port_cfg;
  logic [7:0] pins_q;
  logic ext_in;
  logic ext_q;
  logic armed;
  logic ext_edge;
  logic port_edge;

  // Alternate source lets a board route the request elsewhere
  assign ext_in = port_cfg[`CIC_PORT_CFG_EXT_SEL] ? port_pins[0] : ext_irq_alt_in;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= 8'h00;
      ext_q <= 1'b0;
    end else begin
      pins_q <= port_pins;
      ext_q <= ext_in;
    end
  end

  // Pins may idle high behind pull-ups, so the first sample after reset is no edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end

  assign ext_edge = port_cfg[`CIC_PORT_CFG_RISING] ? (ext_in && !ext_q) : (!ext_in && ext_q);
  assign port_edge = armed && (|(port_pins[7:4] ^ pins_q[7:4]));
  assign ev = {timer_zero_overflow, ext_edge, port_edge};

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CIC_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= pwdata[7:0];
      end
      // Set beats a same-cycle firmware clear so no event is lost
      if (ev.timer_overflow) begin
        ctrl.timer_overflow_flag <= 1'b1;
      end
      if (ev.ext_pin) begin
        ctrl.ext_pin_irq_flag <= 1'b1;
      end
      if (ev.port_change) begin
        ctrl.port_change_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_cfg <= `CIC_PORT_CFG_RESET;
    end else if (wr && hit_cfg) begin
      port_cfg <= pwdata[1:0];
    end
  end

  // ****************************************
  // Core request
  // ****************************************
  logic tmr_req;
  logic ext_req;
  logic port_req;
  logic next_core_irq_req;

  assign tmr_req = ctrl.timer_overflow_irq_enable && ctrl.timer_overflow_flag;
  assign ext_req = ctrl.ext_pin_irq_enable && ctrl.ext_pin_irq_flag;
  assign port_req = ctrl.port_change_irq_enable && ctrl.port_change_flag;
  // All three sources are core sources; peripheral group has no members here
  assign next_core_irq_req = ctrl.global_irq_enable && (tmr_req || ext_req || port_req);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq_req <= 1'b0;
    end else begin
      core_irq_req <= next_core_irq_req;
    end
  end

  // ****************************************
  // System interrupt status and mask
  // ****************************************
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] ev_vec;

  assign ev_vec = ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `CIC_STATUS_RESET;
    end else if (wr && hit_stat) begin
      irq_status <= (irq_status & ~pwdata[2:0]) | ev_vec;
    end else begin
      irq_status <= irq_status | ev_vec;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `CIC_MASK_RESET;
    end else if (wr && hit_mask) begin
      irq_mask <= pwdata[2:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_ctrl) begin
        prdata <= {24'h00_0000, ctrl};
      end else if (hit_stat) begin
        prdata <= {29'h0000_0000, irq_status};
      end else if (hit_mask) begin
        prdata <= {29'h0000_0000, irq_mask};
      end else if (hit_cfg) begin
        prdata <= {30'h0000_0000, port_cfg};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_flag_set_any_enable;
    @(posedge pclk) disable iff (!presetn)
    ev.timer_overflow |=> ctrl.timer_overflow_flag;
  endproperty
  a_flag_set_any_enable: assert property (p_flag_set_any_enable) else $error("timer flag not set");

  property p_global_blocks;
    @(posedge pclk) disable iff (!presetn)
    !ctrl.global_irq_enable |=> !core_irq_req;
  endproperty
  a_global_blocks: assert property (p_global_blocks) else $error("request without global enable");

  property p_peripheral_gate;
    @(posedge pclk) disable iff (!presetn)
    (ctrl.global_irq_enable && !ctrl.peripheral_group_enable && tmr_req) |=> core_irq_req;
  endproperty
  a_peripheral_gate: assert property (p_peripheral_gate) else $error("core source gated by group enable");

  property p_timer_enable;
    @(posedge pclk) disable iff (!presetn)
    (ctrl.global_irq_enable && ctrl.timer_overflow_flag && ctrl.timer_overflow_irq_enable) |=> core_irq_req;
  endproperty
  a_timer_enable: assert property (p_timer_enable) else $error("timer request missing");

  property p_ext_enable;
    @(posedge pclk) disable iff (!presetn)
    (ctrl.global_irq_enable && ctrl.ext_pin_irq_flag && ctrl.ext_pin_irq_enable) |=> core_irq_req;
  endproperty
  a_ext_enable: assert property (p_ext_enable) else $error("external request missing");

  property p_port_enable;
    @(posedge pclk) disable iff (!presetn)
    (ctrl.global_irq_enable && ctrl.port_change_flag && ctrl.port_change_irq_enable) |=> core_irq_req;
  endproperty
  a_port_enable: assert property (p_port_enable) else $error("port change request missing");

  property p_timer_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
    (ctrl.timer_overflow_flag && !wr_ctrl) |=> ctrl.timer_overflow_flag;
  endproperty
  a_timer_flag_sticky: assert property (p_timer_flag_sticky) else $error("timer flag cleared by hardware");

  property p_ext_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
    (ctrl.ext_pin_irq_flag && !wr_ctrl) |=> ctrl.ext_pin_irq_flag;
  endproperty
  a_ext_flag_sticky: assert property (p_ext_flag_sticky) else $error("external flag dropped");

  property p_port_change_sets;
    @(posedge pclk) disable iff (!presetn)
    (armed && $past(port_pins[7:4]) != port_pins[7:4]) |=> ctrl.port_change_flag;
  endproperty
  a_port_change_sets: assert property (p_port_change_sets) else $error("port change not flagged");

  property p_bank_alias;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_ctrl) |=> (prdata[7:0] == $past(ctrl));
  endproperty
  a_bank_alias: assert property (p_bank_alias) else $error("bank read mismatch");

  property p_ext_select;
    @(posedge pclk) disable iff (!presetn)
    (port_cfg == 2'h3 && port_pins[0] && !ext_q) |=> ctrl.ext_pin_irq_flag;
  endproperty
  a_ext_select: assert property (p_ext_select) else $error("pin 0 edge not flagged");

  property p_no_spurious_req;
    @(posedge pclk) disable iff (!presetn)
    !(tmr_req || ext_req || port_req) |=> !core_irq_req;
  endproperty
  a_no_spurious_req: assert property (p_no_spurious_req) else $error("request with no enabled flag");

  property p_ext_flag_any_enable;
    @(posedge pclk) disable iff (!presetn)
    ev.ext_pin |=> ctrl.ext_pin_irq_flag;
  endproperty
  a_ext_flag_any_enable: assert property (p_ext_flag_any_enable) else $error("external flag not set");

  property p_port_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
    (ctrl.port_change_flag && !wr_ctrl) |=> ctrl.port_change_flag;
  endproperty
  a_port_flag_sticky: assert property (p_port_flag_sticky) else $error("port change flag dropped");

  property p_ctrl_write_lands;
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !(|ev)) |=> (ctrl == $past(pwdata[7:0]));
  endproperty
  a_ctrl_write_lands: assert property (p_ctrl_write_lands) else $error("control write lost");

  property p_ext_falling;
    @(posedge pclk) disable iff (!presetn)
    (port_cfg == 2'h1 && !port_pins[0] && ext_q) |=> ctrl.ext_pin_irq_flag;
  endproperty
  a_ext_falling: assert property (p_ext_falling) else $error("pin 0 falling edge not flagged");

  property p_timer_req_gated;
    @(posedge pclk) disable iff (!presetn)
    (!ctrl.timer_overflow_irq_enable && !ext_req && !port_req) |=> !core_irq_req;
  endproperty
  a_timer_req_gated: assert property (p_timer_req_gated) else $error("timer request while disabled");

  property p_ext_req_gated;
    @(posedge pclk) disable iff (!presetn)
    (!ctrl.ext_pin_irq_enable && !tmr_req && !port_req) |=> !core_irq_req;
  endproperty
  a_ext_req_gated: assert property (p_ext_req_gated) else $error("external request while disabled");

  property p_port_req_gated;
    @(posedge pclk) disable iff (!presetn)
    (!ctrl.port_change_irq_enable && !tmr_req && !ext_req) |=> !core_irq_req;
  endproperty
  a_port_req_gated: assert property (p_port_req_gated) else $error("port request while disabled");

  property p_status_sticky;
    @(posedge pclk) disable iff (!presetn)
    !(wr && hit_stat) |=> ((irq_status & $past(irq_status)) == $past(irq_status));
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status bit dropped without clear");

  property p_status_follows_event;
    @(posedge pclk) disable iff (!presetn)
    (|ev_vec) |=> ((irq_status & $past(ev_vec)) == $past(ev_vec));
  endproperty
  a_status_follows_event: assert property (p_status_follows_event) else $error("status bit missed an event");

  property p_unmapped_read_zero;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && unmapped) |=> (prdata == 32'h0000_0000);
  endproperty
  a_unmapped_read_zero: assert property (p_unmapped_read_zero) else $error("unmapped read not zero");

  // ****************************************
  // Cover points
  // ****************************************
  c_timer_req: cover property (@(posedge pclk) disable iff (!presetn) ev.timer_overflow ##[1:20] core_irq_req);
  c_bank1_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && paddr == {2'h0, `CIC_IDX_CTRL_BANK1, 2'h0});
  c_set_beats_clear: cover property (@(posedge pclk) disable iff (!presetn) wr_ctrl && ev.port_change);
  c_ext_rising: cover property (@(posedge pclk) disable iff (!presetn) port_cfg[`CIC_PORT_CFG_RISING] && ev.ext_pin);
  c_alt_source: cover property (@(posedge pclk) disable iff (!presetn) !port_cfg[`CIC_PORT_CFG_EXT_SEL] && ev.ext_pin);

endmodule
`default_nettype wire

//--- pkg/cic_defines.svh
// Register offsets, field positions and reset values of the interrupt control block
`ifndef CIC_DEFINES_SVH
`define CIC_DEFINES_SVH
// Offsets 0x0b and 0x8b are word indices; the byte address is four times the index
`define CIC_IDX_CTRL_BANK0 8'h0b
`define CIC_IDX_CTRL_BANK1 8'h8b
`define CIC_IDX_IRQ_STATUS 8'h40
`define CIC_IDX_IRQ_MASK 8'h41
`define CIC_IDX_PORT_CFG 8'h42
`define CIC_BIT_GLOBAL_EN 7
`define CIC_BIT_PERIPH_EN 6
`define CIC_BIT_TIMER_EN 5
`define CIC_BIT_EXT_EN 4
`define CIC_BIT_PORT_EN 3
`define CIC_BIT_TIMER_FLAG 2
`define CIC_BIT_EXT_FLAG 1
`define CIC_BIT_PORT_FLAG 0
`define CIC_CTRL_RESET 8'h00
`define CIC_STATUS_RESET 3'h0
`define CIC_MASK_RESET 3'h0
`define CIC_PORT_CFG_RESET 2'h1
`define CIC_PORT_CFG_EXT_SEL 0
`define CIC_PORT_CFG_RISING 1
`endif

//--- pkg/cic_pkg.sv
// Types shared by the interrupt control block
package cic_pkg;
  typedef struct packed {
    logic timer_overflow;
    logic ext_pin;
    logic port_change;
  } cic_events_t;

  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_group_enable;
    logic timer_overflow_irq_enable;
    logic ext_pin_irq_enable;
    logic port_change_irq_enable;
    logic timer_overflow_flag;
    logic ext_pin_irq_flag;
    logic port_change_flag;
  } cic_ctrl_t;
endpackage

//--- verification/cic_core_model.sv
// Behavioural processor core that counts interrupt requests
`timescale 1ns/1ns
`default_nettype none
module cic_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic core_irq_req,
  output logic [7:0] n_req
);
  logic req_q;
  // Rising edges only, as a core enters its handler once per request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 1'b0;
      n_req <= 8'h00;
    end else begin
      req_q <= core_irq_req;
      if (core_irq_req && !req_q)
        n_req <= n_req + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_cic_top.sv
// Self-checking bench for the interrupt control block
`timescale 1ns/1ns
`default_nettype none
module tb_cic_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic timer_zero_overflow, ext_irq_alt_in, core_irq_req, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] port_pins, n_req, c;
  int n_fail = 0;
  int comparisons = 0;
  cic_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_zero_overflow(timer_zero_overflow), .port_pins(port_pins), .ext_irq_alt_in(ext_irq_alt_in),
    .core_irq_req(core_irq_req), .irq(irq));
  cic_core_model i_core (.pclk(pclk), .presetn(presetn), .core_irq_req(core_irq_req), .n_req(n_req));
  // ********************
  // Clock, checks and bus
  // ********************
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic close_out;
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits on pready; only the watchdog ends a stuck transfer
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic exp_req(input logic [7:0] v);
    return v[7] & (|(v[5:3] & v[2:0]));
  endfunction
  task automatic fire(input int s);
    case (s)
      0: begin
        timer_zero_overflow <= 1'b1;
        @(posedge pclk);
        timer_zero_overflow <= 1'b0;
      end
      1: begin
        port_pins[0] <= 1'b1;
        repeat (3) @(posedge pclk);
        port_pins[0] <= 1'b0;
      end
      default: port_pins <= port_pins ^ (8'h10 << $urandom_range(3));
    endcase
    repeat (3) @(posedge pclk);
  endtask
  // ********************
  // Tests
  // ********************
  initial begin
    {presetn, psel, penable, pwrite, timer_zero_overflow, ext_irq_alt_in} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hf;
    port_pins = 8'h00;
    void'($urandom(19));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h02c, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk({31'h0, pready}, 32'h1);
    repeat (8) begin
      c = 8'($urandom);
      apb(1'b1, 12'h02c, {24'h0, c});
      apb(1'b0, 12'h22c, 32'h0);
      chk(rd, {24'h0, c});
      repeat (2) @(posedge pclk);
      chk({31'h0, core_irq_req}, {31'h0, exp_req(c)});
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, core_irq_req}, 32'h0);
    chk(prdata, 32'h0);
    chk({31'h0, irq}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, 12'h22c, 32'h0);
    chk(rd, 32'h0);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, 12'h02c, 32'h0);
      apb(1'b1, 12'h100, 32'h7);
      apb(1'b1, 12'h104, 32'h0);
      fire(s);
      apb(1'b0, 12'h02c, 32'h0);
      chk(rd, 32'h4 >> s);
      chk({31'h0, core_irq_req}, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk(rd, 32'h4 >> s);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, 12'h104, 32'h4 >> s);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, 12'h02c, 32'h80 | (32'h20 >> s) | (32'h4 >> s));
      repeat (2) @(posedge pclk);
      chk({31'h0, core_irq_req}, 32'h1);
      apb(1'b1, 12'h100, 32'h4 >> s);
      apb(1'b0, 12'h100, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    apb(1'b1, 12'h02c, 32'h0);
    apb(1'b1, 12'h108, 32'h3);
    port_pins[0] <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, 12'h02c, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, 12'h02c, 32'h0);
    port_pins[0] <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(1'b0, 12'h02c, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h108, 32'h0);
    ext_irq_alt_in <= 1'b1;
    repeat (2) @(posedge pclk);
    ext_irq_alt_in <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(1'b0, 12'h22c, 32'h0);
    chk(rd, 32'h2);
    chk({24'h0, n_req}, 32'h3);
    close_out();
  end
  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
